// ---- include/flash_seq_pkg.sv ----
package flash_seq_pkg;
    // geometry
    localparam int PAGES       = 1024;
    localparam int PAGE_BIG    = 264;
    localparam int PAGE_SMALL  = 256;
    localparam int BUF_DEPTH   = 264;
    localparam int PAGE_W      = 10;
    localparam int OFS_W       = 9;
    localparam int MIDX_W      = 19;
    localparam int HDR_BYTES   = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // opcodes
    localparam logic [7:0] OP_PROG_NOERASE = 8'h88;
    localparam logic [7:0] OP_PROG_ERASE   = 8'h82;
    localparam logic [7:0] OP_BYTE_PROG    = 8'h02;
    localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;
    // address field positions
    localparam int PAGE_LSB_BIG   = 9;
    localparam int PAGE_LSB_SMALL = 8;
    // self-timed durations, microseconds, arbitrary plain defaults
    localparam int CLK_MHZ             = 100;
    localparam int PAGE_PROG_TIME_US   = 2000;
    localparam int ERASE_PROG_TIME_US  = 4000;
    localparam int PAGE_ERASE_TIME_US  = 2000;
    localparam int BYTE_PROG_TIME_US   = 8;
    // longest times: cycle counts round down (exact at integer MHz)
    localparam int PAGE_PROG_CYC  = PAGE_PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_PROG_CYC = ERASE_PROG_TIME_US * CLK_MHZ;
    localparam int PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CLK_MHZ;
    localparam int BYTE_PROG_CYC  = BYTE_PROG_TIME_US * CLK_MHZ;
    // host serial clock half period in system cycles
    localparam int SCK_HALF       = 4;
    localparam int CS_GAP_HALVES  = 4;

    // page number field of the 24-bit address
    function automatic logic [PAGE_W-1:0] addr_page(
        input logic [23:0] a, input logic big);
        addr_page = big ? a[PAGE_LSB_BIG +: PAGE_W]
                        : a[PAGE_LSB_SMALL +: PAGE_W];
    endfunction : addr_page

    // buffer start offset field of the 24-bit address
    function automatic logic [OFS_W-1:0] addr_offset(
        input logic [23:0] a, input logic big);
        addr_offset = big ? a[OFS_W-1:0] : {1'b0, a[7:0]};
    endfunction : addr_offset

    // build the three address bytes, don't-care bits sent as zero
    function automatic logic [23:0] addr_build(
        input logic [PAGE_W-1:0] pg, input logic [OFS_W-1:0] ofs,
        input logic big);
        addr_build = big ? {5'h00, pg, ofs} : {6'h00, pg, ofs[7:0]};
    endfunction : addr_build
endpackage : flash_seq_pkg

// ---- include/flash_link_if.sv ----
`timescale 1ns/10ps
// serial link between host and flash sequencer, spi mode 0
interface flash_link_if;
    logic cs_n;   // chip select, active low
    logic sck;    // serial clock from host
    logic mosi;   // serial data host to device
    modport host (output cs_n, output sck, output mosi);
    modport dev  (input cs_n, input sck, input mosi);
endinterface : flash_link_if

// ---- core/spi_byte_rx.sv ----
`timescale 1ns/10ps
module spi_byte_rx (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // asynchronous link pins
    input  wire logic       cs_n_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    // received stream
    output logic [7:0]      byte_out,
    output logic            byte_valid_out,
    output logic            frame_start_out,
    output logic            frame_end_out,
    output logic [2:0]      bit_phase_out
);
    // two-stage synchronisers plus a history stage for edges
    logic [2:0] cs_q, sck_q;     // [0] first stage, [1] second, [2] old
    logic [1:0] si_q;
    logic [6:0] sh_q;            // partial byte
    logic [2:0] bit_q;           // bits of the partial byte

    // edges are taken between stage two and history only
    wire sck_rise = sck_q[1] & ~sck_q[2];
    wire cs_fall  = ~cs_q[1] & cs_q[2];
    wire cs_rise  = cs_q[1] & ~cs_q[2];
    wire bit_take = sck_rise & ~cs_q[1];

    // synchronisers and edge history
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cs_q  <= 3'h7;
            sck_q <= 3'h0;
            si_q  <= 2'h0;
        end else begin
            cs_q  <= {cs_q[1:0], cs_n_in};
            sck_q <= {sck_q[1:0], sck_in};
            si_q  <= {si_q[0], mosi_in};
        end
    end

    // msb-first shifter; phase kept after frame end for abort checks
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sh_q           <= 7'h00;
            bit_q          <= 3'h0;
            byte_out       <= 8'h00;
            byte_valid_out <= 1'b0;
        end else begin
            byte_valid_out <= 1'b0;
            if (cs_fall) begin
                bit_q <= 3'h0;
            end else if (bit_take) begin
                sh_q  <= {sh_q[5:0], si_q[1]};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    byte_out       <= {sh_q, si_q[1]};
                    byte_valid_out <= 1'b1;
                end
            end
        end
    end

    // frame markers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            frame_start_out <= 1'b0;
            frame_end_out   <= 1'b0;
        end else begin
            frame_start_out <= cs_fall;
            frame_end_out   <= cs_rise;
        end
    end

    assign bit_phase_out = bit_q;
endmodule : spi_byte_rx

// ---- core/flash_seq_dev.sv ----
`timescale 1ns/10ps
// Functional notes
// - big mode 88h: page in bits 18..9
// - small mode 88h: page in bits 17..8
// - 88h programs buffer into page, busy held
// - host must pre-erase before programming without erase
// - verify failure sets the fail flag
// - big mode 82h: page plus 9-bit offset
// - small mode 82h: page plus 8-bit offset
// - data bytes fill buffer, wrapping to zero
// - 82h erases page then programs buffer
// - big mode 02h: 1 to 264 bytes
// - small mode 02h: 18-bit byte address
// - 02h programs only bytes received
// - 02h mid-byte deselect aborts the program; bytes already loaded stay in the buffer
// - 02h duration scales with byte count
// - big mode 81h: page in bits 18..9
// - small mode 81h: page in bits 17..8
// - 81h erases page to all ones
module flash_seq_dev
    import flash_seq_pkg::*;
#(
    parameter int PAGE_PROG_CYC_P  = PAGE_PROG_CYC,
    parameter int ERASE_PROG_CYC_P = ERASE_PROG_CYC,
    parameter int PAGE_ERASE_CYC_P = PAGE_ERASE_CYC,
    parameter int BYTE_PROG_CYC_P  = BYTE_PROG_CYC
) (
    // clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    // link
    flash_link_if.dev              link,
    // configuration
    input  wire logic              page_big_in,
    // status
    output logic                   busy_out,
    output logic                   prog_erase_fail_flag_out,
    output logic                   op_done_out,
    // array inspection port, one cycle latency
    input  wire logic [PAGE_W-1:0] rd_page_in,
    input  wire logic [OFS_W-1:0]  rd_offset_in,
    output logic [7:0]             rd_data_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} seq_t;

    // array and buffer storage; array has no reset, like real cells
    logic [7:0] mem_q [0:PAGES*BUF_DEPTH-1];
    logic [7:0] buf_q [0:BUF_DEPTH-1];
    logic [BUF_DEPTH-1:0] mark_q;      // bytes loaded this frame

    seq_t              st_q;           // sequencer state
    logic [2:0]        hdr_q;          // header bytes seen, saturating
    logic [7:0]        op_q;           // opcode of current frame
    logic [23:0]       addr_q;         // address bytes
    logic [OFS_W-1:0]  wptr_q;         // buffer write pointer
    logic [OFS_W:0]    nld_q;          // data bytes loaded, saturating
    logic [PAGE_W-1:0] page_q;         // page under operation
    logic [OFS_W-1:0]  idx_q;          // byte walker
    logic [31:0]       tmr_q;          // self-timed duration left
    logic              go_prog_q;      // erase is followed by program

    // receiver
    logic [7:0] rx_byte;
    logic       rx_valid, rx_start, rx_end;
    logic [2:0] rx_phase;

    spi_byte_rx u_rx (
        .clk_sys_in      (clk_sys_in),
        .rst_in          (rst_in),
        .cs_n_in         (link.cs_n),
        .sck_in          (link.sck),
        .mosi_in         (link.mosi),
        .byte_out        (rx_byte),
        .byte_valid_out  (rx_valid),
        .frame_start_out (rx_start),
        .frame_end_out   (rx_end),
        .bit_phase_out   (rx_phase)
    );

    // flat array index of a page byte
    function automatic logic [MIDX_W-1:0] mem_index(
        input logic [PAGE_W-1:0] pg, input logic [OFS_W-1:0] ofs);
        mem_index = MIDX_W'(pg * BUF_DEPTH + ofs);
    endfunction : mem_index

    // decode of the incoming frame
    wire        idle      = (st_q == ST_IDLE);
    wire        hdr_done  = (hdr_q == 3'(HDR_BYTES));
    wire [23:0] addr_full = {addr_q[15:0], rx_byte};
    wire        is_fill   = (op_q == OP_PROG_ERASE) |
                            (op_q == OP_BYTE_PROG);
    wire        take_hdr  = rx_valid & idle & ~hdr_done;
    wire        take_dat  = rx_valid & idle & hdr_done & is_fill;
    wire [OFS_W-1:0] page_sz = page_big_in ? OFS_W'(PAGE_BIG)
                                           : OFS_W'(PAGE_SMALL);
    wire [OFS_W-1:0] wptr_nx = (wptr_q == page_sz - OFS_W'(1)) ?
                               '0 : wptr_q + OFS_W'(1);
    wire        op_known  = (op_q == OP_PROG_NOERASE) | is_fill |
                            (op_q == OP_PAGE_ERASE);
    wire        bad_end   = (op_q == OP_BYTE_PROG) &&
                            (rx_phase != 3'h0);
    wire        launch    = rx_end & idle & hdr_done & op_known &
                            ~bad_end;
    wire        do_erase  = (op_q == OP_PROG_ERASE) |
                            (op_q == OP_PAGE_ERASE);
    wire [31:0] dur       =
        (op_q == OP_PROG_ERASE) ? 32'(ERASE_PROG_CYC_P) :
        (op_q == OP_PAGE_ERASE) ? 32'(PAGE_ERASE_CYC_P) :
        (op_q == OP_BYTE_PROG)  ? 32'(nld_q) * 32'(BYTE_PROG_CYC_P) :
                                  32'(PAGE_PROG_CYC_P);

    // sequencer side of the walk
    wire        last_idx  = (idx_q == page_sz - OFS_W'(1));
    wire [MIDX_W-1:0] midx = mem_index(page_q, idx_q);
    wire [7:0]  old_b     = mem_q[midx];
    wire [7:0]  new_b     = old_b & buf_q[idx_q];  // cells only clear
    wire        prog_en   = (st_q == ST_PROG) &&
                            ((op_q != OP_BYTE_PROG) || mark_q[idx_q]);
    wire        verify_bad = prog_en && (new_b != buf_q[idx_q]);

    // frame capture: opcode, address bytes and buffer fill
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            hdr_q  <= 3'h0;
            op_q   <= 8'h00;
            addr_q <= 24'h000000;
            wptr_q <= '0;
            nld_q  <= '0;
        end else if (rx_start & idle) begin
            hdr_q <= 3'h0;
            nld_q <= '0;
        end else if (take_hdr) begin
            hdr_q <= hdr_q + 3'h1;
            if (hdr_q == 3'h0) begin
                op_q <= rx_byte;
            end else begin
                addr_q <= addr_full;
            end
            if (hdr_q == 3'(HDR_BYTES - 1)) begin
                // offset width follows the page mode
                wptr_q <= addr_offset(addr_full, page_big_in);
            end
        end else if (take_dat) begin
            wptr_q <= wptr_nx;
            if (nld_q != 10'(page_sz)) begin
                nld_q <= nld_q + 10'h001;
            end
        end
    end

    // buffer write; busy frames never touch the buffer
    always_ff @(posedge clk_sys_in) begin
        if (take_dat) begin
            buf_q[wptr_q] <= rx_byte;
        end
    end

    // loaded-byte marks, cleared at each new idle frame
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mark_q <= '0;
        end else if (rx_start & idle) begin
            mark_q <= '0;
        end else if (take_dat) begin
            mark_q[wptr_q] <= 1'b1;
        end
    end

    // array writes during the walk
    always_ff @(posedge clk_sys_in) begin
        if (st_q == ST_ERASE) begin
            mem_q[midx] <= ERASED_BYTE;
        end else if (prog_en) begin
            mem_q[midx] <= new_b;
        end
    end

    // sequencer: walk the page, then wait out the self-timed duration
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_q      <= ST_IDLE;
            page_q    <= '0;
            idx_q     <= '0;
            tmr_q     <= 32'h00000000;
            go_prog_q <= 1'b0;
        end else begin
            if (tmr_q != 32'h00000000) begin
                tmr_q <= tmr_q - 32'h00000001;
            end
            case (st_q)
                ST_IDLE: begin
                    if (launch) begin
                        // page field position follows the page mode
                        page_q    <= addr_page(addr_q, page_big_in);
                        idx_q     <= '0;
                        tmr_q     <= dur;
                        go_prog_q <= (op_q == OP_PROG_ERASE);
                        st_q      <= do_erase ? ST_ERASE : ST_PROG;
                    end
                end
                ST_ERASE: begin
                    idx_q <= last_idx ? '0 : idx_q + OFS_W'(1);
                    if (last_idx) begin
                        st_q <= go_prog_q ? ST_PROG : ST_WAIT;
                    end
                end
                ST_PROG: begin
                    idx_q <= last_idx ? '0 : idx_q + OFS_W'(1);
                    if (last_idx) begin
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // short duration parameters end right after the walk
                    if (tmr_q <= 32'h00000001) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // status outputs; the fail flag describes the last operation
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            busy_out                 <= 1'b0;
            prog_erase_fail_flag_out <= 1'b0;
            op_done_out              <= 1'b0;
        end else begin
            op_done_out <= (st_q == ST_WAIT) && (tmr_q <= 32'h00000001);
            if (launch) begin
                busy_out                 <= 1'b1;
                prog_erase_fail_flag_out <= 1'b0;
            end else if ((st_q == ST_WAIT) && (tmr_q <= 32'h00000001)) begin
                busy_out <= 1'b0;
            end
            if (verify_bad) begin
                prog_erase_fail_flag_out <= 1'b1;
            end
        end
    end

    // inspection read port
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= mem_q[mem_index(rd_page_in, rd_offset_in)];
        end
    end
endmodule : flash_seq_dev

// ---- core/flash_seq_host.sv ----
`timescale 1ns/10ps
module flash_seq_host
    import flash_seq_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    // link
    flash_link_if.host             link,
    // command request
    input  wire logic              req_valid_in,
    input  wire logic [7:0]        req_op_in,
    input  wire logic [PAGE_W-1:0] req_page_in,
    input  wire logic [OFS_W-1:0]  req_offset_in,
    input  wire logic [OFS_W:0]    req_len_in,
    input  wire logic              page_big_in,
    // data bytes for fill commands
    input  wire logic [7:0]        data_in,
    input  wire logic              data_valid_in,
    output logic                   data_ready_out,
    // status
    output logic                   busy_out,
    output logic                   done_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_GAP} host_t;

    host_t        st_q;      // frame state
    logic [7:0]   op_q;      // opcode in flight
    logic [23:0]  addr_q;    // address bytes in flight
    logic [10:0]  left_q;    // bytes still to send
    logic [10:0]  sent_q;    // bytes already sent
    logic [7:0]   sh_q;      // byte being shifted
    logic [2:0]   bit_q;     // bit index in byte
    logic [3:0]   div_q;     // half-period divider
    logic [3:0]   half_q;    // gap half-periods
    logic         cs_n_q, sck_q, mosi_q;

    // byte source and divider tick
    wire tick     = (div_q == 4'(SCK_HALF - 1));
    wire fill_op  = (req_op_in == OP_PROG_ERASE) |
                    (req_op_in == OP_BYTE_PROG);
    // page-only commands carry zero offset bits
    wire [OFS_W-1:0] ofs = fill_op ? req_offset_in : '0;
    wire need_dat = (sent_q >= 11'(HDR_BYTES));
    wire [7:0] hdr_b  = (sent_q == 11'h000) ? op_q :
                        (sent_q == 11'h001) ? addr_q[23:16] :
                        (sent_q == 11'h002) ? addr_q[15:8] : addr_q[7:0];
    wire load_ok  = (left_q != 11'h000) & (~need_dat | data_valid_in);

    // frame sequencing; the caller owns pre-erase ordering
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_q   <= ST_IDLE;
            op_q   <= 8'h00;
            addr_q <= 24'h000000;
            left_q <= '0;
            sent_q <= '0;
            sh_q   <= 8'h00;
            bit_q  <= 3'h0;
            div_q  <= 4'h0;
            half_q <= 4'h0;
            cs_n_q <= 1'b1;
            sck_q  <= 1'b0;
            mosi_q <= 1'b0;
            data_ready_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            data_ready_out <= 1'b0;
            done_out       <= 1'b0;
            div_q <= tick ? 4'h0 : div_q + 4'h1;
            case (st_q)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        op_q   <= req_op_in;
                        // field layout per page mode
                        addr_q <= addr_build(req_page_in, ofs, page_big_in);
                        // header plus data
                        left_q <= 11'(HDR_BYTES) +
                                  (fill_op ? 11'(req_len_in) : 11'h000);
                        sent_q <= '0;
                        cs_n_q <= 1'b0;
                        busy_out <= 1'b1;
                        st_q   <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (load_ok) begin
                        sh_q   <= need_dat ? data_in : hdr_b;
                        mosi_q <= need_dat ? data_in[7] : hdr_b[7];
                        data_ready_out <= need_dat;
                        bit_q  <= 3'h0;
                        div_q  <= 4'h0;
                        st_q   <= ST_SHIFT;
                    end else if (left_q == 11'h000) begin
                        half_q <= 4'h0;
                        st_q   <= ST_GAP;
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        sck_q <= ~sck_q;
                        if (sck_q) begin
                            // falling edge: next bit, whole bytes only
                            sh_q   <= {sh_q[6:0], 1'b0};
                            mosi_q <= sh_q[6];
                            bit_q  <= bit_q + 3'h1;
                            if (bit_q == 3'h7) begin
                                left_q <= left_q - 11'h001;
                                sent_q <= sent_q + 11'h001;
                                st_q   <= ST_LOAD;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    // raise select, then hold it high before the next
                    if (tick) begin
                        cs_n_q <= 1'b1;
                        half_q <= half_q + 4'h1;
                        if (half_q == 4'(CS_GAP_HALVES)) begin
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            st_q     <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // link pins straight from flops
    assign link.cs_n = cs_n_q;
    assign link.sck  = sck_q;
    assign link.mosi = mosi_q;
endmodule : flash_seq_host

// ---- verif/flash_page_program_erase_cmds_checker.sv ----
`timescale 1ns/10ps
// link framing and device status timing
module flash_page_program_erase_cmds_checker (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // link pins, active low select
    input  wire logic cs_n_in,
    input  wire logic sck_in,
    input  wire logic mosi_in,
    // device status
    input  wire logic busy_in,
    input  wire logic op_done_in
);
    // all checks run on the system clock
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // one high phase of the serial clock, four system cycles
    sequence sck_half_s;
        sck_in [*4] ##1 !sck_in;
    endsequence

    // serial clock parks low outside a frame
    chk_sck_idle_low: assert property (
        cs_n_in |-> !sck_in)
        else $error("sck high while deselected");
    // data only moves while the serial clock is low
    chk_mosi_on_low: assert property (
        !cs_n_in && $changed(mosi_in) |-> !sck_in)
        else $error("mosi moved while sck high");
    chk_sck_half_len: assert property (
        $rose(sck_in) |-> sck_half_s)
        else $error("sck high phase not four cycles");
    // launch only follows a deselect, two synchroniser stages later
    chk_launch_after_cs: assert property (
        $rose(busy_in) |-> $past(cs_n_in, 2))
        else $error("busy rose without deselect");
    chk_busy_min_len: assert property (
        $rose(busy_in) |-> busy_in [*8])
        else $error("busy too short");
    chk_fall_gives_done: assert property (
        $fell(busy_in) |-> op_done_in)
        else $error("busy fell without done");
    chk_done_only_end: assert property (
        op_done_in |-> $past(busy_in) && !busy_in)
        else $error("done without busy end");
    chk_no_launch_frame: assert property (
        !cs_n_in |=> !$rose(busy_in))
        else $error("launch inside frame");
endmodule : flash_page_program_erase_cmds_checker

// ---- verif/test_flash_page_program_erase_cmds.sv ----
`timescale 1ns/10ps
module test_flash_page_program_erase_cmds;
    import flash_seq_pkg::*;
    localparam int BYTE_CYC = 300;  // shortened per-byte program time
    logic clk_sys_in, rst_in, big, req_valid, data_ready, hbusy, hdone;
    logic busy, fail, op_done;
    logic [7:0] req_op, rd_data, dbase;
    logic [7:0] dcnt = 8'h00;         // data bytes taken, never cleared
    wire  [7:0] data = dbase + dcnt;  // byte k of a frame is d0 plus k
    logic [PAGE_W-1:0] req_page, rd_page;
    logic [OFS_W-1:0] req_ofs, rd_ofs;
    logic [OFS_W:0] req_len;
    int failures = 0, n_checks = 0, cycles = 0, bcnt;
    flash_link_if lk();
    flash_seq_host i_flash_seq_host (.clk_sys_in, .rst_in, .link(lk),
        .req_valid_in(req_valid), .req_op_in(req_op), .req_page_in(req_page),
        .req_offset_in(req_ofs), .req_len_in(req_len), .page_big_in(big),
        .data_in(data), .data_valid_in(1'b1), .data_ready_out(data_ready),
        .busy_out(hbusy), .done_out(hdone));
    flash_seq_dev #(.PAGE_PROG_CYC_P(600), .ERASE_PROG_CYC_P(800),
        .PAGE_ERASE_CYC_P(300), .BYTE_PROG_CYC_P(BYTE_CYC)) i_flash_seq_dev (
        .clk_sys_in, .rst_in, .link(lk), .page_big_in(big), .busy_out(busy),
        .prog_erase_fail_flag_out(fail), .op_done_out(op_done),
        .rd_page_in(rd_page), .rd_offset_in(rd_ofs), .rd_data_out(rd_data));
    flash_page_program_erase_cmds_checker i_chk (.clk_sys_in, .rst_in,
        .cs_n_in(lk.cs_n), .sck_in(lk.sck), .mosi_in(lk.mosi),
        .busy_in(busy), .op_done_in(op_done));
    initial begin
        clk_sys_in = 0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // one process owns the byte count, so data has a single driver
    always @(negedge clk_sys_in) if (data_ready) dcnt <= dcnt + 8'h01;
    // hang guard, well above the longest run
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one host request, then wait for the device to finish
    task automatic op(input logic [7:0] o, input logic [PAGE_W-1:0] p,
        input logic [OFS_W-1:0] f, input int n, input logic [7:0] d0);
        logic hseen;  // host frame end pulse seen
        hseen = 1'b0;
        @(negedge clk_sys_in);
        req_op = o;
        req_page = p;
        req_ofs = f;
        req_len = n[OFS_W:0];
        dbase = d0 - dcnt;
        req_valid = 1;
        @(negedge clk_sys_in);
        req_valid = 0;
        chk({7'h00, hbusy}, 8'h01);
        bcnt = 0;
        for (int i = 0; i < 30000 && op_done !== 1'b1; i++) begin
            @(negedge clk_sys_in);
            bcnt += busy;
            hseen |= hdone;
        end
        // a wait that runs out must count, not fall through
        chk({7'h00, hseen}, 8'h01);
        chk({7'h00, op_done}, 8'h01);
    endtask : op
    // array byte, one cycle read latency
    task automatic rd(input logic [PAGE_W-1:0] p, input logic [OFS_W-1:0] f,
        input logic [7:0] exp);
        rd_page = p;
        rd_ofs = f;
        @(negedge clk_sys_in);
        chk(rd_data, exp);
    endtask : rd
    task automatic s_erase();
        op(OP_PAGE_ERASE, 10'h005, 9'h000, 0, 8'h00);
        rd(10'h005, 9'h000, ERASED_BYTE);
        rd(10'h005, 9'h107, ERASED_BYTE);
    endtask : s_erase
    // full buffer from offset 8, wraps past 263
    task automatic s_fill_wrap();
        op(OP_PROG_ERASE, 10'h006, 9'h008, 264, 8'h10);
        chk({7'h00, fail}, 8'h00);
        rd(10'h006, 9'h107, 8'h0F);
        rd(10'h006, 9'h000, 8'h10);
        rd(10'h006, 9'h007, 8'h17);
    endtask : s_fill_wrap
    // programming over data fails; fresh page passes
    task automatic s_noerase();
        op(OP_BYTE_PROG, 10'h006, 9'h000, 1, 8'h80);
        chk({7'h00, fail}, 8'h01);
        rd(10'h006, 9'h001, 8'h11);
        // page 5 was page-erased first
        op(OP_PROG_NOERASE, 10'h005, 9'h000, 0, 8'h00);
        chk({7'h00, fail}, 8'h00);
        rd(10'h005, 9'h000, 8'h80);
        rd(10'h005, 9'h007, 8'h17);
    endtask : s_noerase
    // small pages: three bytes wrap at 255, duration scales
    task automatic s_small();
        big = 0;
        op(OP_PAGE_ERASE, 10'h007, 9'h000, 0, 8'h00);
        op(OP_BYTE_PROG, 10'h007, 9'h0FE, 3, 8'h40);
        chk({7'h00, bcnt >= 3 * BYTE_CYC - 3 && bcnt <= 3 * BYTE_CYC + 3},
            8'h01);
        rd(10'h007, 9'h0FF, 8'h41);
        rd(10'h007, 9'h000, 8'h42);
        rd(10'h007, 9'h001, ERASED_BYTE);
    endtask : s_small
    initial begin
        {rst_in, big, req_valid, req_op, req_page, req_ofs} = '1;
        {req_len, dbase, rd_page, rd_ofs} = '0;
        req_valid = 0;
        repeat (16) @(negedge clk_sys_in);
        rst_in = 0;
        repeat (8) @(negedge clk_sys_in);
        s_erase();
        s_fill_wrap();
        s_noerase();
        s_small();
        conclude();
    end
endmodule : test_flash_page_program_erase_cmds
